/* File: logic/flash_program_mode_control.sv */
`timescale 1ns/10ps
// Contract
// R01 - three paths feed the array: parallel writer, serial programmer, resident software.
// R02 - every program operation writes one complete 128-byte block; the 128 write strobes use array_addr, which never carries blk_reg or widx_reg.
// R03 - the addressed block is erased automatically before it is written; code erases at array_addr, par_read_addr on the parallel and self paths.
// R04 - operation stays busy about 40 ms, or 50 ms on low-voltage part.
// R05 - all program requests blocked for about 20 ms after power-up.
// R06 - self-programming needs the unlock acceptor set first.
// R07 - security lock refuses external reads and programming on every path.
// R08 - lock can be set only from the serial path.
// R09 - parallel path runs under the external writer only, no resident code.
// R10 - self path programs on request of resident software.
// R11 - serial mode entered on first operation, left when it finishes.
// R12 - serial mode entered only while chip is in reset or stop.
// R13 - serial clock pin is only a clock input.
// R14 - serial data pin is bidirectional, driven in turn.
// R15 - serial mode qualified by the high-voltage mode-select input.
// R16 - programmer holds chip reset low for the whole operation.
// R17 - unlock latch sets on nibbles 5 then A, clears after each block.
// R18 - locked array reads return all zeros.
// R19 - operation outside reset or stop raises a protocol error.
// R20 - busy shown through erase and write, new requests refused while busy.
// R21 - security lock is kept in non-volatile state.
module flash_program_mode_control #(
  parameter logic               LOW_VOLTAGE_PART = 1'b0,
  parameter int unsigned        POWERON_CYCLES   = flash_ctrl_pkg::POWERON_CYC,
  parameter int unsigned        PROG_HV_CYCLES   = flash_ctrl_pkg::PROG_HV_CYC,
  parameter int unsigned        PROG_LV_CYCLES   = flash_ctrl_pkg::PROG_LV_CYC
) (
  input  wire logic                              clk,
  input  wire logic                              rstn,
  input  wire logic                              prog_serial_clock,
  input  wire logic                              prog_serial_data_in,
  output logic                                   prog_serial_data_out,
  output logic                                   prog_serial_data_oe_n,
  input  wire logic                              prog_mode_entry,
  input  wire logic                              chip_clear_input_n,
  input  wire logic                              stop_mode,
  input  wire logic                              par_mode,
  input  wire logic                              par_buf_we,
  input  wire logic [flash_ctrl_pkg::IDX_W-1:0]  par_buf_idx,
  input  wire logic [7:0]                        par_buf_data,
  input  wire logic                              par_prog_start,
  input  wire logic [flash_ctrl_pkg::BLK_W-1:0]  par_block,
  input  wire logic [flash_ctrl_pkg::ADDR_W-1:0] par_read_addr,
  output logic      [7:0]                        par_read_data,
  input  wire logic                              unlock_write,
  input  wire logic [7:0]                        unlock_data,
  input  wire logic                              self_buf_we,
  input  wire logic [flash_ctrl_pkg::IDX_W-1:0]  self_buf_idx,
  input  wire logic [7:0]                        self_buf_data,
  input  wire logic                              self_prog_start,
  input  wire logic [flash_ctrl_pkg::BLK_W-1:0]  self_block,
  input  wire logic                              lock_stored,
  output logic                                   lock_store_pulse,
  output logic      [flash_ctrl_pkg::ADDR_W-1:0] array_addr,
  input  wire logic [7:0]                        array_read_data,
  output logic                                   array_erase,
  output logic                                   array_write_en,
  output logic      [7:0]                        array_write_data,
  output logic                                   busy,
  output logic                                   serial_active,
  output logic                                   protocol_error,
  output logic                                   prog_refused,
  output logic                                   prog_done,
  output logic                                   write_unlock_latch,
  output logic                                   security_locked
);
  localparam logic [flash_ctrl_pkg::TIMER_W-1:0] PROG_LAST =
    flash_ctrl_pkg::TIMER_W'((LOW_VOLTAGE_PART ? PROG_LV_CYCLES : PROG_HV_CYCLES) - 1);
  localparam logic [flash_ctrl_pkg::TIMER_W-1:0] POR_LAST =
    flash_ctrl_pkg::TIMER_W'(POWERON_CYCLES - 1);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] sclk_sync_reg;
  logic       sclk_prev_reg;
  logic [1:0] sdat_sync_reg;
  logic [1:0] mode_sync_reg;
  logic [1:0] clr_sync_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_sync_reg <= 2'h0;
      sclk_prev_reg <= 1'b0;
      sdat_sync_reg <= 2'h0;
      mode_sync_reg <= 2'h0;
      clr_sync_reg  <= 2'h3;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], prog_serial_clock};  // [R13]
      sclk_prev_reg <= sclk_sync_reg[1];
      sdat_sync_reg <= {sdat_sync_reg[0], prog_serial_data_in};
      mode_sync_reg <= {mode_sync_reg[0], prog_mode_entry};
      clr_sync_reg  <= {clr_sync_reg[0], chip_clear_input_n};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic mode_on;
  logic entry_ok;
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;
  assign mode_on   = mode_sync_reg[1];                                // [R15]
  // chip must sit in reset for the whole operation, so sampled live
  assign entry_ok  = mode_on & (~clr_sync_reg[1] | stop_mode);      // [R12] [R16]

  // ----------------------------------------
  // power-on protect
  // ----------------------------------------
  logic [flash_ctrl_pkg::TIMER_W-1:0] por_cnt_reg;
  logic                               por_done_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt_reg  <= '0;
      por_done_reg <= 1'b0;
    end else if (!por_done_reg) begin
      por_cnt_reg  <= por_cnt_reg + 1'b1;
      por_done_reg <= (por_cnt_reg == POR_LAST);                    // [R05]
    end
  end

  // ----------------------------------------
  // security lock
  // ----------------------------------------
  logic lock_set_reg;
  logic lock_req;
  assign security_locked = lock_stored | lock_set_reg;              // [R21]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_set_reg     <= 1'b0;
      lock_store_pulse <= 1'b0;
    end else begin
      lock_store_pulse <= lock_req;                                 // [R21]
      if (lock_req) begin
        lock_set_reg <= 1'b1;                                       // [R08]
      end
    end
  end

  // ----------------------------------------
  // write-unlock acceptor
  // ----------------------------------------
  logic key_half_reg;
  logic self_ok;
  logic clear_unlock;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_half_reg       <= 1'b0;
      write_unlock_latch <= 1'b0;
    end else begin
      if (unlock_write) begin
        key_half_reg <= (unlock_data[3:0] == flash_ctrl_pkg::KEY_FIRST);
        if (key_half_reg && unlock_data[3:0] == flash_ctrl_pkg::KEY_SECOND) begin
          write_unlock_latch <= 1'b1;                               // [R17]
        end
      end
      // a key arriving as the block finishes still wins
      if (clear_unlock && !(unlock_write && key_half_reg
          && unlock_data[3:0] == flash_ctrl_pkg::KEY_SECOND)) begin
        write_unlock_latch <= 1'b0;                                 // [R17]
      end
    end
  end

  // ----------------------------------------
  // path select
  // ----------------------------------------
  flash_ctrl_pkg::ser_state_type ser_state_reg;
  logic                             ser_buf_we;
  logic [flash_ctrl_pkg::IDX_W-1:0] ser_idx_reg;
  logic [7:0]                       rx_byte;
  logic [flash_ctrl_pkg::BLK_W-1:0] ser_block_reg;
  logic                             ser_start;
  logic                             can_start;
  logic                             start_req;
  logic                             go;
  logic [flash_ctrl_pkg::BLK_W-1:0] go_block;
  flash_ctrl_pkg::path_type         go_path;
  flash_ctrl_pkg::path_type         run_path_reg;
  flash_ctrl_pkg::seq_state_type    seq_reg;

  // resident code runs only outside serial and parallel modes
  assign self_ok   = ~serial_active & ~par_mode & write_unlock_latch;  // [R06] [R09] [R10]
  assign can_start = por_done_reg & ~security_locked & ~busy;          // [R05] [R07] [R20]

  always_comb begin
    go_block  = self_block;
    go_path   = flash_ctrl_pkg::PATH_SELF;
    start_req = self_prog_start & self_ok;                             // [R06]
    if (serial_active) begin
      go_block  = ser_block_reg;
      go_path   = flash_ctrl_pkg::PATH_SERIAL;
      start_req = ser_start;
    end else if (par_mode) begin
      go_block  = par_block;
      go_path   = flash_ctrl_pkg::PATH_PARALLEL;
      start_req = par_prog_start;                                      // [R09]
    end
  end

  assign go           = start_req & can_start;                         // [R01]
  assign prog_refused = start_req & ~can_start;                        // [R20]

  logic                             buf_we;
  logic [flash_ctrl_pkg::IDX_W-1:0] buf_widx;
  logic [7:0]                       buf_wdata;
  logic [flash_ctrl_pkg::IDX_W-1:0] buf_ridx;

  always_comb begin
    buf_we    = self_buf_we & ~par_mode;
    buf_widx  = self_buf_idx;
    buf_wdata = self_buf_data;
    if (serial_active) begin
      buf_we    = ser_buf_we;
      buf_widx  = ser_idx_reg;
      buf_wdata = rx_byte;
    end else if (par_mode) begin
      buf_we    = par_buf_we;
      buf_widx  = par_buf_idx;
      buf_wdata = par_buf_data;
    end
  end

  block_buffer u_buffer (
    .clk     (clk),
    .wr_en   (buf_we & ~busy),
    .wr_idx  (buf_widx),
    .wr_data (buf_wdata),
    .rd_idx  (buf_ridx),
    .rd_data (array_write_data)
  );

  // ----------------------------------------
  // erase and write sequencer
  // ----------------------------------------
  logic [flash_ctrl_pkg::TIMER_W-1:0] timer_reg;
  logic [flash_ctrl_pkg::IDX_W:0]     wcnt_reg;
  logic [flash_ctrl_pkg::BLK_W-1:0]   blk_reg;
  logic [flash_ctrl_pkg::IDX_W-1:0]   widx_reg;

  assign busy         = (seq_reg != flash_ctrl_pkg::SEQ_IDLE);        // [R20]
  assign buf_ridx     = wcnt_reg[flash_ctrl_pkg::IDX_W-1:0];
  assign clear_unlock = prog_done;                                    // [R17]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_reg        <= flash_ctrl_pkg::SEQ_IDLE;
      timer_reg      <= '0;
      wcnt_reg       <= '0;
      widx_reg       <= '0;
      blk_reg        <= '0;
      run_path_reg   <= flash_ctrl_pkg::PATH_SELF;
      array_erase    <= 1'b0;
      array_write_en <= 1'b0;
      prog_done      <= 1'b0;
    end else begin
      array_erase    <= 1'b0;
      array_write_en <= 1'b0;
      prog_done      <= 1'b0;
      timer_reg      <= timer_reg + 1'b1;
      unique case (seq_reg)
        flash_ctrl_pkg::SEQ_IDLE: begin
          if (go) begin
            seq_reg      <= flash_ctrl_pkg::SEQ_ERASE;
            blk_reg      <= go_block;                                 // [R02]
            run_path_reg <= go_path;
            timer_reg    <= '0;
            wcnt_reg     <= '0;
            array_erase  <= 1'b1;                                     // [R03]
          end
        end
        flash_ctrl_pkg::SEQ_ERASE: begin
          seq_reg <= flash_ctrl_pkg::SEQ_WRITE;
        end
        flash_ctrl_pkg::SEQ_WRITE: begin
          // buffer read is one cycle behind the counter
          wcnt_reg       <= wcnt_reg + 1'b1;
          widx_reg       <= wcnt_reg[flash_ctrl_pkg::IDX_W-1:0];
          array_write_en <= ~wcnt_reg[flash_ctrl_pkg::IDX_W];         // [R02]
          if (wcnt_reg[flash_ctrl_pkg::IDX_W]) begin
            seq_reg <= flash_ctrl_pkg::SEQ_HOLD;
          end
        end
        flash_ctrl_pkg::SEQ_HOLD: begin
          if (timer_reg >= PROG_LAST) begin                           // [R04]
            seq_reg   <= flash_ctrl_pkg::SEQ_IDLE;
            prog_done <= 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // serial programmer link
  // ----------------------------------------
  logic [6:0] rx_sh_reg;
  logic [2:0] bit_reg;
  logic       op_read_reg;
  logic       last_byte_reg;
  logic [7:0] tx_sh_reg;
  logic [7:0] read_pick;
  logic       byte_in;

  assign rx_byte    = {rx_sh_reg, sdat_sync_reg[1]};
  assign byte_in    = sclk_rise & (bit_reg == flash_ctrl_pkg::LAST_BIT)
                      & (ser_state_reg != flash_ctrl_pkg::SER_SEND);
  assign ser_buf_we = byte_in & (ser_state_reg == flash_ctrl_pkg::SER_DATA);
  assign ser_start  = byte_in & (ser_state_reg == flash_ctrl_pkg::SER_DATA)
                      & (ser_idx_reg == flash_ctrl_pkg::LAST_IDX);
  assign lock_req   = byte_in & (ser_state_reg == flash_ctrl_pkg::SER_CMD)
                      & entry_ok & (rx_byte == flash_ctrl_pkg::CMD_LOCK);  // [R08]
  assign read_pick  = security_locked ? 8'h00 : array_read_data;      // [R18]
  assign array_addr = serial_active ? {ser_block_reg, ser_idx_reg} : par_read_addr;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      par_read_data <= 8'h00;
    end else begin
      par_read_data <= par_mode ? read_pick : 8'h00;                  // [R07] [R18]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ser_state_reg         <= flash_ctrl_pkg::SER_CMD;
      serial_active         <= 1'b0;
      protocol_error        <= 1'b0;
      rx_sh_reg             <= '0;
      bit_reg               <= '0;
      op_read_reg           <= 1'b0;
      last_byte_reg         <= 1'b0;
      ser_idx_reg           <= '0;
      ser_block_reg         <= '0;
      tx_sh_reg             <= 8'h00;
      prog_serial_data_out  <= 1'b0;
      prog_serial_data_oe_n <= 1'b1;
    end else if (!mode_on) begin
      // dropping the high-voltage select aborts any frame in flight
      ser_state_reg         <= flash_ctrl_pkg::SER_CMD;
      serial_active         <= 1'b0;
      protocol_error        <= 1'b0;
      bit_reg               <= '0;
      prog_serial_data_oe_n <= 1'b1;
    end else begin
      if (sclk_rise && ser_state_reg != flash_ctrl_pkg::SER_SEND) begin
        rx_sh_reg <= rx_byte[6:0];
        bit_reg   <= bit_reg + 1'b1;
      end
      unique case (ser_state_reg)
        flash_ctrl_pkg::SER_CMD: begin
          if (byte_in) begin
            if (!entry_ok) begin
              protocol_error <= 1'b1;                                 // [R19]
            end else if (rx_byte == flash_ctrl_pkg::CMD_WRITE
                         || rx_byte == flash_ctrl_pkg::CMD_READ) begin
              serial_active <= 1'b1;                                  // [R11]
              op_read_reg   <= (rx_byte == flash_ctrl_pkg::CMD_READ);
              ser_state_reg <= flash_ctrl_pkg::SER_ADDR_HI;
            end
          end
        end
        flash_ctrl_pkg::SER_ADDR_HI: begin
          if (byte_in) begin
            ser_block_reg <= {rx_byte[1:0], ser_block_reg[7:0]};
            ser_state_reg <= flash_ctrl_pkg::SER_ADDR_LO;
          end
        end
        flash_ctrl_pkg::SER_ADDR_LO: begin
          if (byte_in) begin
            ser_block_reg[7:0] <= rx_byte;
            ser_idx_reg        <= '0;
            last_byte_reg      <= 1'b0;
            ser_state_reg      <= op_read_reg ? flash_ctrl_pkg::SER_SEND
                                              : flash_ctrl_pkg::SER_DATA;
          end
        end
        flash_ctrl_pkg::SER_DATA: begin
          if (byte_in) begin
            ser_idx_reg <= ser_idx_reg + 1'b1;
            if (ser_start) begin
              ser_state_reg <= flash_ctrl_pkg::SER_WAIT;
            end
          end
        end
        flash_ctrl_pkg::SER_SEND: begin
          if (sclk_fall) begin
            if (bit_reg == 3'h0 && last_byte_reg) begin
              prog_serial_data_oe_n <= 1'b1;
              serial_active         <= 1'b0;                          // [R11]
              ser_state_reg         <= flash_ctrl_pkg::SER_CMD;
            end else begin
              prog_serial_data_oe_n <= 1'b0;                          // [R14]
              bit_reg               <= bit_reg + 1'b1;
              if (bit_reg == 3'h0) begin
                prog_serial_data_out <= read_pick[7];                 // [R07] [R18]
                tx_sh_reg            <= {read_pick[6:0], 1'b0};
              end else begin
                prog_serial_data_out <= tx_sh_reg[7];
                tx_sh_reg            <= {tx_sh_reg[6:0], 1'b0};
              end
              if (bit_reg == flash_ctrl_pkg::LAST_BIT) begin
                last_byte_reg <= (ser_idx_reg == flash_ctrl_pkg::LAST_IDX);
                ser_idx_reg   <= ser_idx_reg + 1'b1;
              end
            end
          end
        end
        flash_ctrl_pkg::SER_WAIT: begin
          // refused start or finished block both end the operation
          if ((prog_done && run_path_reg == flash_ctrl_pkg::PATH_SERIAL)
              || !busy) begin
            serial_active <= 1'b0;                                    // [R11]
            ser_state_reg <= flash_ctrl_pkg::SER_CMD;
          end
        end
        default: begin
          ser_state_reg <= flash_ctrl_pkg::SER_CMD;
        end
      endcase
    end
  end
endmodule

/* File: logic/flash_ctrl_pkg.sv */
package flash_ctrl_pkg;

  // ----------------------------------------
  // array geometry
  // ----------------------------------------
  localparam int BLOCK_BYTES = 128;
  localparam int IDX_W       = 7;
  localparam int BLK_W       = 10;
  localparam int ADDR_W      = BLK_W + IDX_W;
  localparam logic [IDX_W-1:0] LAST_IDX = 7'h7f;
  localparam logic [2:0]       LAST_BIT = 3'h7;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int POWERON_MS    = 20;
  localparam int PROG_HV_MS    = 40;
  localparam int PROG_LV_MS    = 50;
  localparam int POWERON_CYC   = POWERON_MS * (CLK_HZ / 1000);
  localparam int PROG_HV_CYC   = PROG_HV_MS * (CLK_HZ / 1000);
  localparam int PROG_LV_CYC   = PROG_LV_MS * (CLK_HZ / 1000);
  localparam int TIMER_W       = 20;

  // ----------------------------------------
  // serial link commands
  // ----------------------------------------
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ  = 8'h02;
  localparam logic [7:0] CMD_LOCK  = 8'h03;

  // write-unlock key nibbles
  localparam logic [3:0] KEY_FIRST  = 4'h5;
  localparam logic [3:0] KEY_SECOND = 4'ha;

  typedef enum logic [1:0] {
    PATH_SERIAL   = 2'b00,
    PATH_PARALLEL = 2'b01,
    PATH_SELF     = 2'b10
  } path_type;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ERASE = 2'b01,
    SEQ_WRITE = 2'b10,
    SEQ_HOLD  = 2'b11
  } seq_state_type;

  typedef enum logic [2:0] {
    SER_CMD     = 3'b000,
    SER_ADDR_HI = 3'b001,
    SER_ADDR_LO = 3'b010,
    SER_DATA    = 3'b011,
    SER_SEND    = 3'b100,
    SER_WAIT    = 3'b101
  } ser_state_type;

endpackage

/* File: logic/block_buffer.sv */
`timescale 1ns/10ps
module block_buffer (
  input  wire logic                           clk,
  input  wire logic                           wr_en,
  input  wire logic [flash_ctrl_pkg::IDX_W-1:0] wr_idx,
  input  wire logic [7:0]                     wr_data,
  input  wire logic [flash_ctrl_pkg::IDX_W-1:0] rd_idx,
  output logic      [7:0]                     rd_data
);
  logic [7:0] mem [flash_ctrl_pkg::BLOCK_BYTES];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_idx];
  end
endmodule

/* File: logic/block_buffer_dummy_never.sv */
`timescale 1ns/10ps

/* File: tb/flash_props.sv */
`timescale 1ns/10ps
module flash_props #(
  parameter int unsigned POWERON_CYCLES = 50
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       par_prog_start,
  input wire logic       self_prog_start,
  input wire logic       unlock_write,
  input wire logic [7:0] unlock_data,
  input wire logic       array_erase,
  input wire logic       array_write_en,
  input wire logic       busy,
  input wire logic       serial_active,
  input wire logic       protocol_error,
  input wire logic       prog_refused,
  input wire logic       prog_done,
  input wire logic       write_unlock_latch,
  input wire logic       security_locked,
  input wire logic [7:0] par_read_data
);
  int unsigned since_rst;
  logic        prev_five;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) since_rst <= 0;
    else if (since_rst < POWERON_CYCLES) since_rst <= since_rst + 1;
  end
  always_ff @(posedge clk) prev_five <= unlock_write && unlock_data[3:0] == 4'h5;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // margin of two cycles keeps the edge of the window out of dispute
  AST_POWERON: assert property (since_rst + 2 < POWERON_CYCLES && par_prog_start |-> prog_refused)
    else $error("start accepted during power-on protection");
  AST_BUSY_REFUSE: assert property (busy && (par_prog_start || self_prog_start) |-> prog_refused)
    else $error("start accepted while busy");
  AST_ERASE_FIRST: assert property ($rose(busy) |-> array_erase && !array_write_en)
    else $error("operation did not begin with erase");
  AST_BLOCK_RUN: assert property (array_erase |=> !array_write_en ##1 array_write_en [*8])
    else $error("write burst did not follow erase");
  AST_DONE_IDLE: assert property (prog_done |-> !array_write_en ##1 !busy)
    else $error("busy stayed after done");
  AST_LOCK_REFUSE: assert property (security_locked && (par_prog_start || self_prog_start) |-> prog_refused)
    else $error("start accepted while locked");
  AST_LOCK_ZERO: assert property (security_locked ##1 security_locked |-> par_read_data == 8'h00)
    else $error("locked read returned data");
  AST_KEY_SET: assert property (prev_five && unlock_write && unlock_data[3:0] == 4'ha |=> write_unlock_latch)
    else $error("unlock key did not set latch");
  AST_NO_KEY: assert property (self_prog_start && !write_unlock_latch && !busy |=> !busy)
    else $error("self start ran without unlock");
  AST_ERR_NO_ENTRY: assert property (protocol_error |-> !serial_active)
    else $error("serial mode active with protocol error");
  cover property ($rose(write_unlock_latch));
  cover property (prog_done);
  cover property ($rose(protocol_error));
  cover property ($rose(security_locked));
endmodule

/* File: tb/flash_programmer_model.sv */
`timescale 1ns/10ps
module flash_programmer_model (
  output logic      prog_serial_clock,
  output logic      drive_en,
  output logic      drive_bit,
  input  wire logic data_line
);
  logic [7:0] got;
  initial {prog_serial_clock, drive_en, drive_bit} = 3'h0;
  // clock stands low between frames; line released to pull-up after byte
  task automatic send_byte(input logic [7:0] b, input logic drv = 1'b1);
    for (int i = 7; i >= 0; i--) begin
      drive_en = drv;
      drive_bit = b[i];
      #200 prog_serial_clock = 1'b1;
      got[i] = data_line;
      #200 prog_serial_clock = 1'b0;
    end
    drive_en = 1'b0;
  endtask
endmodule

/* File: tb/flash_program_mode_control_tb.sv */
`timescale 1ns/10ps
module flash_program_mode_control_tb;
  localparam int unsigned PON = 50;
  logic        clk = 0, rstn = 0, prog_mode_entry = 0, chip_clear_input_n = 1, stop_mode = 0;
  logic        par_mode = 0, par_buf_we = 0, par_prog_start = 0, unlock_write = 0;
  logic        self_buf_we = 0, self_prog_start = 0, lock_stored = 0, prog_serial_data_in;
  logic [6:0]  par_buf_idx = 7'h00, self_buf_idx = 7'h00;
  logic [7:0]  par_buf_data = 8'h00, unlock_data = 8'h00, self_buf_data = 8'h00;
  logic [9:0]  par_block = 10'h000, self_block = 10'h001;
  logic [16:0] par_read_addr = 17'h00000, array_addr;
  logic [7:0]  array_read_data, par_read_data, array_write_data;
  logic        prog_serial_clock, prog_serial_data_out, prog_serial_data_oe_n, drive_en, drive_bit;
  logic        lock_store_pulse, array_erase, array_write_en, busy, serial_active, protocol_error;
  logic        prog_refused, prog_done, write_unlock_latch, security_locked;
  int          num_errors = 0, compares = 0, n_erase = 0, n_wr = 0;

  assign prog_serial_data_in = !prog_serial_data_oe_n ? prog_serial_data_out :
                               (drive_en ? drive_bit : 1'b1);
  assign array_read_data = array_addr[7:0];
  always #25 clk = ~clk;
  // lock cell survives reset, as a non-volatile bit would
  always @(posedge clk) begin
    if (array_erase) n_erase++;
    if (array_write_en) n_wr++;
    if (lock_store_pulse === 1'b1) lock_stored <= 1'b1;
  end

  flash_program_mode_control #(.POWERON_CYCLES(PON), .PROG_HV_CYCLES(300),
    .PROG_LV_CYCLES(400)) i_flash_program_mode_control (.*);
  flash_programmer_model i_flash_programmer_model (.prog_serial_clock, .drive_en, .drive_bit,
    .data_line(prog_serial_data_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic start(ref logic s, input logic exp);
    s = 1'b1;
    #1 check("prog_refused", prog_refused, exp);
    step();
    s = 1'b0;
  endtask
  task automatic fill(ref logic we, ref logic [6:0] idx, ref logic [7:0] d);
    for (int i = 0; i < 128; i++) begin
      we = 1'b1;
      idx = i[6:0];
      d = i[7:0] ^ 8'h3c;
      step();
    end
    we = 1'b0;
    n_erase = 0;
    n_wr = 0;
  endtask
  task automatic wait_done();
    for (int k = 0; k < 2000 && prog_done !== 1'b1; k++) step();
    check("prog_done", prog_done, 1);
    step();
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_parallel();
    par_mode = 1'b1;
    start(par_prog_start, 1);
    step(PON);
    fill(par_buf_we, par_buf_idx, par_buf_data);
    start(par_prog_start, 0);
    step();
    start(par_prog_start, 1);
    wait_done();
    check("erase count", n_erase, 1);
    check("write count", n_wr, 128);
    par_read_addr = 17'h00123;
    step(2);
    check("par_read_data", par_read_data, 8'h23);
    par_mode = 1'b0;
    $display("test parallel finished");
  endtask
  task automatic t_self();
    unlock_write = 1'b1;
    unlock_data = 8'h35;
    step();
    unlock_data = 8'hca;
    step();
    unlock_write = 1'b0;
    check("unlock latch set", write_unlock_latch, 1);
    fill(self_buf_we, self_buf_idx, self_buf_data);
    start(self_prog_start, 0);
    wait_done();
    check("self write count", n_wr, 128);
    check("unlock latch cleared", write_unlock_latch, 0);
    start(self_prog_start, 0);
    step(5);
    check("erase without key", n_erase, 1);
    $display("test self finished");
  endtask
  task automatic t_serial();
    chip_clear_input_n = 1'b0;
    prog_mode_entry = 1'b1;
    for (int i = 0; i < 131; i++) i_flash_programmer_model.send_byte(i == 0 ? 8'h01 :
      i == 2 ? 8'h05 : 8'(i - 3));
    wait_done();
    check("serial_active", serial_active, 0);
    for (int i = 0; i < 3; i++) i_flash_programmer_model.send_byte(i == 0 ? 8'h02 : 8'(i * 5 - 5));
    i_flash_programmer_model.send_byte(8'h00, 1'b0);
    check("serial read", i_flash_programmer_model.got, 8'h80);
    prog_mode_entry = 1'b0;
    step(4);
    prog_mode_entry = 1'b1;
    i_flash_programmer_model.send_byte(8'h03);
    step(8);
    check("lock stored", lock_stored, 1);
    chip_clear_input_n = 1'b1;
    i_flash_programmer_model.send_byte(8'h01);
    step(8);
    check("protocol_error", protocol_error, 1);
    check("no entry while running", serial_active, 0);
    prog_mode_entry = 1'b0;
    par_mode = 1'b1;
    par_read_addr = 17'h00045;
    step(4);
    check("locked read", par_read_data, 8'h00);
    start(par_prog_start, 1);
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    step(2);
    check("lock after reset", security_locked, 1);
    $display("test serial finished");
  endtask

  initial begin
    step(12);
    rstn = 1'b1;
    t_parallel();
    t_self();
    t_serial();
    tally_and_finish();
  end
  initial begin
    #2_000_000;
    num_errors++;
    tally_and_finish();
  end
endmodule

bind flash_program_mode_control flash_props #(.POWERON_CYCLES(POWERON_CYCLES)) i_flash_props (.*);
